/* File: rtl/wakeup_regs_pkg.sv */
// Package of offsets, field positions, reset values and timing for the wake-up register bank
package wakeup_regs_pkg;
    // Printed register indices; not all are multiples of four, so byte address is index times four
    localparam logic [7:0] idx_cap_sense_control = 8'h2e;
    localparam logic [7:0] idx_cap_sense_display = 8'h2f;
    localparam logic [7:0] idx_wakeup_timer_control = 8'h31;
    localparam logic [7:0] idx_amplitude_config = 8'h32;
    localparam logic [7:0] idx_auxiliary_status = 8'h40;
    localparam logic [7:0] idx_misc_control = 8'h41;
    // Reset values
    localparam logic [7:0] rst_reg = 8'h00;
    // Field positions
    localparam int cal_hi = 7;
    localparam int cal_lo = 3;
    localparam int cal_end_bit = 2;
    localparam int cal_err_bit = 1;
    localparam int wur_bit = 7;
    localparam int wut_hi = 6;
    localparam int wut_lo = 4;
    localparam int wto_bit = 3;
    localparam int wam_bit = 2;
    localparam int wph_bit = 1;
    localparam int wcap_bit = 0;
    localparam int amd_hi = 7;
    localparam int amd_lo = 4;
    // Misc control: bit 0 issues the set-default command (self clearing)
    localparam int set_default_bit = 0;
    // Allowed gain codes
    localparam logic [2:0] gain_2p8 = 3'h0;
    localparam logic [2:0] gain_6p5 = 3'h1;
    localparam logic [2:0] gain_1p1 = 3'h2;
    localparam logic [2:0] gain_0p5 = 3'h4;
    localparam logic [2:0] gain_0p35 = 3'h6;
    // Calibration step and full scale in femtofarads
    localparam int cal_step_ff = 100;
    localparam int cal_full_ff = 3100;
    // Timing
    localparam int clk_mhz = 200;
    localparam int tick_us = 1000;
    localparam int tick_cycles = tick_us * clk_mhz;
    localparam int base_long_ms = 100;
    localparam int base_short_ms = 10;
endpackage : wakeup_regs_pkg

/* File: rtl/ms_tick_divider.sv */
// Divider giving a one-cycle tick every programmed number of clocks
`timescale 1ns/1ps
module ms_tick_divider #(
    parameter int unsigned period = 200000
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Run enable and tick out
    input wire logic run,
    output logic tick
);
    logic [31:0] count; // Cycles into current period
    logic [31:0] next_count;
    logic next_tick;

    // Count while running, restart when stopped
    always_comb begin
        next_count = count;
        next_tick = 1'b0;
        if (!run) begin
            next_count = 32'h0;
        end else if (count == 32'(period - 1)) begin
            next_count = 32'h0;
            next_tick = 1'b1;
        end else begin
            next_count = count + 32'h1;
        end
    end

    // Register state
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            count <= 32'h0;
            tick <= 1'b0;
        end else begin
            count <= next_count;
            tick <= next_tick;
        end
    end
endmodule : ms_tick_divider

/* File: rtl/wakeup_sense_status_regs.sv */
// Wake-up, capacitive sensor and auxiliary status register bank on classic Wishbone
//
// Chosen here: the Wishbone register port.
`timescale 1ns/1ps
module wakeup_sense_status_regs
    import wakeup_regs_pkg::*;
#(
    parameter int unsigned tick_period = tick_cycles
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [9:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // Set-default command from the command decoder
    input wire logic set_default,
    // Calibration engine results
    input wire logic [4:0] cal_result,
    input wire logic cal_done,
    input wire logic cal_fail,
    // Live status sources
    input wire logic channel_pm,
    input wire logic field_detect,
    input wire logic tx_active,
    input wire logic osc_running,
    input wire logic osc_stable,
    input wire logic rx_enabled,
    input wire logic rx_receiving,
    input wire logic peer_detect_mode,
    input wire logic collision_avoid_flag,
    // Measurement engine
    input wire logic meas_done,
    input wire logic [7:0] amp_result,
    input wire logic [7:0] amp_reference,
    input wire logic phase_over,
    input wire logic cap_over,
    // Sensor controls to the analog side
    output logic cal_auto,
    output logic [4:0] cal_manual,
    output logic [2:0] sensor_gain,
    output logic gain_valid,
    // Measurement triggers and interrupt
    output logic amp_meas_start,
    output logic phase_meas_start,
    output logic cap_meas_start,
    output logic wakeup_irq
);
    typedef enum logic [2:0] {
        st_idle = 3'b001,
        st_count = 3'b010,
        st_measure = 3'b100
    } timer_state_t;

    // Register storage
    logic [7:0] cap_sense_control;
    logic [7:0] cap_sense_display;
    logic [7:0] wakeup_timer_control;
    logic [7:0] amplitude_config;
    logic [7:0] auxiliary_status;
    logic [7:0] next_cap_sense_control;
    logic [7:0] next_cap_sense_display;
    logic [7:0] next_wakeup_timer_control;
    logic [7:0] next_amplitude_config;
    logic [7:0] next_auxiliary_status;
    // Bus answer
    logic [31:0] next_dat_o;
    logic next_ack;
    logic set_default_req; // Self-clearing command bit
    logic next_set_default_req;
    logic clear_all; // Set-default from either source
    logic [7:0] reg_idx; // Word index from byte address
    logic wr_lane; // Low byte lane enabled for write

    assign reg_idx = adr_i[9:2];
    assign wr_lane = sel_i[0];
    assign clear_all = set_default | set_default_req;

    // Register file and bus answer: one-cycle ack, dropped the cycle after
    // Writes commit at the edge where the master samples ack, so an abandoned cycle stores nothing
    always_comb begin
        next_cap_sense_control = cap_sense_control;
        next_wakeup_timer_control = wakeup_timer_control;
        next_amplitude_config = amplitude_config;
        next_set_default_req = 1'b0;
        next_dat_o = 32'h0;
        next_ack = 1'b0;
        // Read decode while the request waits for its ack
        if (cyc_i && stb_i && !ack_o) begin
            next_ack = 1'b1;
            if (reg_idx == idx_cap_sense_control) begin
                next_dat_o = {24'h0, cap_sense_control};
            end else if (reg_idx == idx_cap_sense_display) begin
                next_dat_o = {24'h0, cap_sense_display};
            end else if (reg_idx == idx_wakeup_timer_control) begin
                next_dat_o = {24'h0, wakeup_timer_control};
            end else if (reg_idx == idx_amplitude_config) begin
                next_dat_o = {24'h0, amplitude_config};
            end else if (reg_idx == idx_auxiliary_status) begin
                next_dat_o = {24'h0, auxiliary_status};
            end else begin
                next_dat_o = 32'h0; // Unmapped and command index read zero
            end
        end
        // Write decode at the ack edge; only the low byte lane carries data
        if (cyc_i && stb_i && ack_o && we_i && wr_lane) begin
            if (reg_idx == idx_cap_sense_control) begin
                next_cap_sense_control = dat_i[7:0];
            end else if (reg_idx == idx_wakeup_timer_control) begin
                next_wakeup_timer_control = dat_i[7:0];
            end else if (reg_idx == idx_amplitude_config) begin
                next_amplitude_config = dat_i[7:0];
            end else if (reg_idx == idx_misc_control) begin
                next_set_default_req = dat_i[set_default_bit];
            end else begin
                next_set_default_req = 1'b0; // Display, status and unmapped writes dropped
            end
        end
        if (clear_all) begin
            next_cap_sense_control = rst_reg;
            next_wakeup_timer_control = rst_reg;
            next_amplitude_config = rst_reg;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cap_sense_control <= rst_reg;
            wakeup_timer_control <= rst_reg;
            amplitude_config <= rst_reg;
            set_default_req <= 1'b0;
            dat_o <= 32'h0;
            ack_o <= 1'b0;
        end else begin
            cap_sense_control <= next_cap_sense_control;
            wakeup_timer_control <= next_wakeup_timer_control;
            amplitude_config <= next_amplitude_config;
            set_default_req <= next_set_default_req;
            dat_o <= next_dat_o;
            ack_o <= next_ack;
        end
    end

    // Status capture; reads never alter these
    always_comb begin
        next_cap_sense_display = {cal_result, cal_done, cal_fail, 1'b0};
        next_auxiliary_status = {channel_pm, field_detect, tx_active,
            osc_running & osc_stable, rx_enabled, rx_receiving,
            peer_detect_mode, collision_avoid_flag};
        if (clear_all) begin
            next_cap_sense_display = rst_reg;
            next_auxiliary_status = rst_reg;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cap_sense_display <= rst_reg;
            auxiliary_status <= rst_reg;
        end else begin
            cap_sense_display <= next_cap_sense_display;
            auxiliary_status <= next_auxiliary_status;
        end
    end

    // Sensor controls; gain code checked against the five legal values
    logic next_cal_auto;
    logic next_gain_valid;
    logic [2:0] gain_code;
    assign gain_code = cap_sense_control[2:0];

    always_comb begin
        next_cal_auto = (cap_sense_control[cal_hi:cal_lo] == 5'h0);
        next_gain_valid = (gain_code == gain_2p8) || (gain_code == gain_6p5) ||
            (gain_code == gain_1p1) || (gain_code == gain_0p5) || (gain_code == gain_0p35);
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cal_auto <= 1'b1;
            cal_manual <= 5'h0;
            sensor_gain <= 3'h0;
            gain_valid <= 1'b1;
        end else begin
            cal_auto <= next_cal_auto;
            cal_manual <= cap_sense_control[cal_hi:cal_lo]; // Binary 0.1 pF steps
            sensor_gain <= gain_code;
            gain_valid <= next_gain_valid;
        end
    end

    // Wake-up timer: millisecond tick from the divider
    logic any_wake; // Some wake-up function enabled
    logic ms_tick;
    logic [9:0] ms_count; // Milliseconds elapsed
    logic [9:0] ms_limit; // Programmed timeout in ms
    logic [9:0] next_ms_count;
    timer_state_t state;
    timer_state_t next_state;
    logic next_amp_start;
    logic next_phase_start;
    logic next_cap_start;
    logic next_irq;
    logic [7:0] amp_diff;
    logic meas_amp_pending; // Amplitude compare awaited
    logic next_meas_amp_pending;

    assign any_wake = |wakeup_timer_control[wto_bit:wcap_bit];
    // Timeout = (code + 1) * base
    assign ms_limit = 10'(({7'h0, wakeup_timer_control[wut_hi:wut_lo]} + 10'h1)
        * (wakeup_timer_control[wur_bit] ? 10'(base_short_ms) : 10'(base_long_ms)));
    assign amp_diff = (amp_result > amp_reference) ? 8'(amp_result - amp_reference)
        : 8'(amp_reference - amp_result);

    ms_tick_divider #(
        .period(tick_period)
    ) u_tick (
        .clk(clk),
        .rstn(rstn),
        .run(any_wake && state == st_count),
        .tick(ms_tick)
    );

    // Timer sequencing and interrupt pulses
    always_comb begin
        next_state = state;
        next_ms_count = ms_count;
        next_amp_start = 1'b0;
        next_phase_start = 1'b0;
        next_cap_start = 1'b0;
        next_irq = 1'b0;
        next_meas_amp_pending = meas_amp_pending;
        case (state)
            st_idle: begin
                next_ms_count = 10'h0;
                if (any_wake) next_state = st_count;
            end
            st_count: begin
                if (!any_wake) begin
                    next_state = st_idle;
                end else if (ms_tick) begin
                    if (ms_count + 10'h1 >= ms_limit) begin
                        next_ms_count = 10'h0; // Restart for periodic timeouts
                        next_irq = wakeup_timer_control[wto_bit];
                        next_amp_start = wakeup_timer_control[wam_bit];
                        next_phase_start = wakeup_timer_control[wph_bit];
                        next_cap_start = wakeup_timer_control[wcap_bit];
                        next_meas_amp_pending = wakeup_timer_control[wam_bit];
                        if (|wakeup_timer_control[wam_bit:wcap_bit]) next_state = st_measure;
                    end else begin
                        next_ms_count = ms_count + 10'h1;
                    end
                end
            end
            st_measure: begin
                // Wait for the engine; the timer holds meanwhile
                if (meas_done) begin
                    next_irq = (meas_amp_pending
                        && amp_diff > {4'h0, amplitude_config[amd_hi:amd_lo]})
                        || (wakeup_timer_control[wph_bit] && phase_over)
                        || (wakeup_timer_control[wcap_bit] && cap_over);
                    next_meas_amp_pending = 1'b0;
                    next_state = any_wake ? st_count : st_idle;
                end
            end
            default: next_state = st_idle;
        endcase
        if (clear_all) begin
            next_state = st_idle;
            next_meas_amp_pending = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state <= st_idle;
            ms_count <= 10'h0;
            meas_amp_pending <= 1'b0;
            amp_meas_start <= 1'b0;
            phase_meas_start <= 1'b0;
            cap_meas_start <= 1'b0;
            wakeup_irq <= 1'b0;
        end else begin
            state <= next_state;
            ms_count <= next_ms_count;
            meas_amp_pending <= next_meas_amp_pending;
            amp_meas_start <= next_amp_start;
            phase_meas_start <= next_phase_start;
            cap_meas_start <= next_cap_start;
            wakeup_irq <= next_irq;
        end
    end

    // Checks; all sampled on the rising edge and silenced while reset is low
    a_cal_auto_sel: assert property (@(posedge clk) disable iff (!rstn)
        cap_sense_control[cal_hi:cal_lo] == 5'h0 |=> cal_auto) else $error("auto calibration not selected");
    a_gain_reject: assert property (@(posedge clk) disable iff (!rstn)
        gain_code == 3'h3 || gain_code == 3'h5 || gain_code == 3'h7 |=> !gain_valid)
        else $error("unused gain accepted");
    a_display_clear: assert property (@(posedge clk) disable iff (!rstn)
        clear_all |=> cap_sense_display == 8'h0 && auxiliary_status == 8'h0) else $error("display not cleared");
    a_channel_mirror: assert property (@(posedge clk) disable iff (!rstn)
        !clear_all |=> auxiliary_status[7:6] == {$past(channel_pm), $past(field_detect)})
        else $error("channel bits wrong");
    a_tx_mirror: assert property (@(posedge clk) disable iff (!rstn)
        !clear_all |=> auxiliary_status[5] == $past(tx_active)) else $error("tx bit wrong");
    a_osc_stable: assert property (@(posedge clk) disable iff (!rstn)
        auxiliary_status[4] |-> $past(osc_running) && $past(osc_stable)) else $error("osc bit wrong");
    a_rx_mirror: assert property (@(posedge clk) disable iff (!rstn)
        !clear_all |=> auxiliary_status[3:2] == {$past(rx_enabled), $past(rx_receiving)})
        else $error("receiver bits wrong");
    a_field_modes: assert property (@(posedge clk) disable iff (!rstn)
        !clear_all |=> auxiliary_status[1:0] == {$past(peer_detect_mode), $past(collision_avoid_flag)})
        else $error("field mode bits wrong");
    a_timer_cleared: assert property (@(posedge clk) disable iff (!rstn)
        clear_all |=> wakeup_timer_control == 8'h0) else $error("timer control not cleared");
    a_irq_timeout: assert property (@(posedge clk) disable iff (!rstn)
        state == st_count && ms_tick && !clear_all && wakeup_timer_control[wto_bit]
        && ms_count + 10'h1 >= ms_limit |=> wakeup_irq) else $error("timeout irq missing");
    a_amp_start: assert property (@(posedge clk) disable iff (!rstn)
        amp_meas_start |-> $past(wakeup_timer_control[wam_bit])) else $error("stray amplitude start");
    a_amp_irq: assert property (@(posedge clk) disable iff (!rstn)
        state == st_measure && meas_done && meas_amp_pending && !clear_all
        && amp_diff > {4'h0, amplitude_config[amd_hi:amd_lo]} |=> wakeup_irq)
        else $error("amplitude irq missing");
    a_timer_wrap: assert property (@(posedge clk) disable iff (!rstn)
        amp_meas_start || phase_meas_start || cap_meas_start |-> ms_count == 10'h0)
        else $error("timer not restarted");
endmodule : wakeup_sense_status_regs

/* File: verif/testbench.sv */
// Self-checking bench for the wake-up, sensor and status register bank
`timescale 1ns/1ps
module testbench;
    import wakeup_regs_pkg::*;
    localparam int unsigned tp = 10; // Short tick so timer test periods stay at most a thousand cycles
    // Clock, reset and bus
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic cyc_i = 0, stb_i = 0, we_i = 0;
    logic [9:0] adr_i = '0;
    logic [3:0] sel_i = '0;
    logic [31:0] dat_i = '0;
    logic [31:0] dat_o;
    logic ack_o;
    // Side inputs
    logic set_default = 0, meas_done = 0, phase_over = 0, cap_over = 0, cal_done = 0, cal_fail = 0;
    logic [4:0] cal_result = '0;
    logic [8:0] live = '0; // Bit 8 is oscillator stable, bits 7..0 the status sources
    logic [7:0] amp_result = '0, amp_reference = '0;
    // Outputs
    logic cal_auto, gain_valid, amp_meas_start, phase_meas_start, cap_meas_start, wakeup_irq;
    logic [4:0] cal_manual;
    logic [2:0] sensor_gain;
    wire logic [3:0] events = {cap_meas_start, phase_meas_start, amp_meas_start, wakeup_irq};
    int n_errors = 0;
    int num_checks = 0;
    logic [31:0] rd;

    wakeup_sense_status_regs #(.tick_period(tp)) uut (.clk(clk), .rstn(rstn), .cyc_i(cyc_i), .stb_i(stb_i),
        .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
        .set_default(set_default), .cal_result(cal_result), .cal_done(cal_done), .cal_fail(cal_fail),
        .channel_pm(live[7]), .field_detect(live[6]), .tx_active(live[5]), .osc_running(live[4]),
        .osc_stable(live[8]), .rx_enabled(live[3]), .rx_receiving(live[2]), .peer_detect_mode(live[1]),
        .collision_avoid_flag(live[0]), .meas_done(meas_done), .amp_result(amp_result),
        .amp_reference(amp_reference), .phase_over(phase_over), .cap_over(cap_over), .cal_auto(cal_auto),
        .cal_manual(cal_manual), .sensor_gain(sensor_gain), .gain_valid(gain_valid),
        .amp_meas_start(amp_meas_start), .phase_meas_start(phase_meas_start), .cap_meas_start(cap_meas_start),
        .wakeup_irq(wakeup_irq));

    // Free-running 200 MHz clock
    initial begin
        forever #2.5 clk = ~clk;
    end

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : print_verdict

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    // One classic cycle; ack is sampled at the edge, so read data is the value at that edge
    task automatic wb(input logic [7:0] idx, input logic we, input logic [31:0] wd, input logic [3:0] sel,
                      output logic [31:0] data);
        int i;
        @(posedge clk);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= we;
        adr_i <= {idx, 2'b00};
        dat_i <= wd;
        sel_i <= sel;
        for (i = 0; i < 20; i++) begin
            @(posedge clk);
            if (ack_o === 1'b1) break;
        end
        data = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i <= 1'b0;
        if (i == 20) begin
            n_errors++;
            print_verdict();
        end
    endtask : wb

    task automatic wr(input logic [7:0] idx, input logic [31:0] wd);
        logic [31:0] d;
        wb(idx, 1'b1, wd, 4'h1, d);
    endtask : wr

    // Count edges until one of the masked events is high; a required event that never comes ends the run
    task automatic wait_for(input logic [3:0] mask, input int bound, input bit must, output logic [3:0] got,
                            output int n);
        for (n = 1; n <= bound; n++) begin
            @(posedge clk);
            got = events;
            if ((got & mask) != 4'h0) return;
        end
        got = 4'h0;
        if (must) begin
            n_errors++;
            print_verdict();
        end
    endtask : wait_for

    task automatic t_reset;
        wb(idx_cap_sense_control, 0, 0, 4'hf, rd);
        check(rd, 32'h0);
        wb(idx_cap_sense_display, 0, 0, 4'hf, rd);
        check(rd, 32'h0);
        wb(idx_auxiliary_status, 0, 0, 4'hf, rd);
        check(rd, 32'h0);
        wb(idx_wakeup_timer_control, 0, 0, 4'hf, rd);
        check(rd, 32'h0);
        check(cal_auto, 1'b1);
        $display("test reset done");
    endtask : t_reset

    task automatic t_cap_ctrl;
        logic [7:0] v;
        for (int g = 0; g < 8; g++) begin
            v = {5'(g * 4 + 3), 3'(g)}; // Reaches full-scale code 31 at the last step
            wr(idx_cap_sense_control, {24'h0, v});
            repeat (2) @(posedge clk);
            check(cal_manual, v[7:3]);
            check(sensor_gain, v[2:0]);
            check(gain_valid, (g == 0 || g == 1 || g == 2 || g == 4 || g == 6));
            check(cal_auto, 1'b0);
            wb(idx_cap_sense_control, 0, 0, 4'hf, rd);
            check(rd, {24'h0, v});
        end
        wr(idx_cap_sense_control, 32'h07);
        repeat (2) @(posedge clk);
        check(cal_auto, 1'b1);
        wb(idx_cap_sense_control, 1, 32'hf8, 4'he, rd); // Low lane off, so dropped
        wb(idx_cap_sense_control, 0, 0, 4'hf, rd);
        check(rd, 32'h07);
        $display("test cap control done");
    endtask : t_cap_ctrl

    task automatic t_display;
        cal_result <= 5'h15;
        cal_done <= 1'b1;
        cal_fail <= 1'b1;
        repeat (2) @(posedge clk);
        wr(idx_cap_sense_display, 32'h00);
        wb(idx_cap_sense_display, 0, 0, 4'hf, rd);
        check(rd, 32'hae);
        wb(idx_cap_sense_display, 0, 0, 4'hf, rd);
        check(rd, 32'hae);
        cal_fail <= 1'b0;
        repeat (2) @(posedge clk);
        wb(idx_cap_sense_display, 0, 0, 4'hf, rd);
        check(rd, 32'hac);
        wb(8'h10, 1, 32'h5a, 4'hf, rd);
        wb(8'h10, 0, 0, 4'hf, rd);
        check(rd, 32'h0);
        $display("test display done");
    endtask : t_display

    task automatic t_aux;
        logic [8:0] v;
        logic [7:0] e;
        for (int i = 0; i < 10; i++) begin
            v = (i == 9) ? 9'h110 : 9'(1 << i);
            e = v[7:0];
            e[4] = v[4] & v[8]; // Running alone is not enough
            live <= v;
            repeat (2) @(posedge clk);
            wr(idx_auxiliary_status, 32'hff);
            wb(idx_auxiliary_status, 0, 0, 4'hf, rd);
            check(rd, {24'h0, e});
        end
        live <= '0;
        $display("test aux done");
    endtask : t_aux

    task automatic t_timer;
        logic [7:0] ctl [3] = '{8'h88, 8'hf8, 8'h08};
        int exp_c [3] = '{10 * tp, 80 * tp, 100 * tp};
        logic [3:0] got;
        int n;
        for (int k = 0; k < 3; k++) begin
            wr(idx_wakeup_timer_control, {24'h0, ctl[k]});
            wait_for(4'h1, 2 * exp_c[k] + 50, 1'b1, got, n);
            wait_for(4'h1, 2 * exp_c[k] + 50, 1'b1, got, n);
            check(got, 4'h1);
            check(n, exp_c[k]);
        end
        wr(idx_wakeup_timer_control, 32'h0);
        $display("test timer done");
    endtask : t_timer

    task automatic t_measure;
        logic [7:0] ctl [5] = '{8'h84, 8'h84, 8'h82, 8'h81, 8'h81};
        logic [7:0] res [5] = '{8'h50, 8'h44, 8'h40, 8'h40, 8'h40};
        logic ovr [5] = '{0, 0, 1, 1, 0};
        logic [3:0] got;
        int n;
        wr(idx_amplitude_config, 32'h40);
        amp_reference <= 8'h40;
        for (int k = 0; k < 5; k++) begin
            wr(idx_wakeup_timer_control, {24'h0, ctl[k]});
            wait_for(4'he, 400, 1'b1, got, n);
            check(got, {ctl[k][0], ctl[k][1], ctl[k][2], 1'b0});
            amp_result <= res[k];
            phase_over <= ovr[k];
            cap_over <= ovr[k];
            meas_done <= 1'b1;
            @(posedge clk);
            meas_done <= 1'b0;
            // Fixed window: a missing interrupt is the expected outcome for some cases
            wait_for(4'h1, 4, 1'b0, got, n);
            check(got[0], (k == 0 || k == 2 || k == 3));
            wr(idx_wakeup_timer_control, 32'h0);
        end
        $display("test measure done");
    endtask : t_measure

    task automatic t_set_default;
        for (int k = 0; k < 2; k++) begin
            wr(idx_cap_sense_control, 32'hfa);
            wr(idx_wakeup_timer_control, 32'h88);
            if (k == 0) begin
                @(posedge clk) set_default <= 1'b1;
                @(posedge clk) set_default <= 1'b0;
            end else begin
                wr(idx_misc_control, 32'h01);
            end
            // Command bit clears one edge after the write, outputs follow one edge later
            repeat (3) @(posedge clk);
            check(cal_auto, 1'b1);
            wb(idx_cap_sense_control, 0, 0, 4'hf, rd);
            check(rd, 32'h0);
            wb(idx_wakeup_timer_control, 0, 0, 4'hf, rd);
            check(rd, 32'h0);
        end
        $display("test set default done");
    endtask : t_set_default

    // Main sequence
    initial begin
        repeat (6) @(posedge clk);
        rstn <= 1'b1;
        t_reset();
        t_cap_ctrl();
        t_display();
        t_aux();
        t_timer();
        t_measure();
        t_set_default();
        print_verdict();
    end
endmodule : testbench
